// File: design/pcn_top.sv
// PLL enable, reset, detector and gate control with regional and I/O clock routing.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcn_defs.svh"

// Operation
// - Enable pin low forces all four loop output ports low and drops lock.
// - Enable pin high again makes the loop reacquire lock and resync.
// - Reset high clears counters and output clocks and forces unlocked.
// - During reset the oscillator returns to its nominal 700 MHz.
// - After reset release the loop relocks starting from nominal frequency.
// - Detector disabled holds oscillator frequency, slow downward drift, outputs run.
// - Every regional and global output port has its own gate enable.
// - Gate synchronously switches the port by gating its post-scale counter.
// - Gate enable is sampled on the counter output falling edge.
// - Gating outputs leaves feedback counters alone, so lock is kept.
// - Each quadrant has four regional networks fed by pins or loop outputs.
// - Networks 0..3 top-left, 8..11 top-right, 4..7 bottom-left, 12..15 bottom-right.
// - Each I/O region takes eight clocks selected from 22 resources.
module pcn_top
  import pcn_pkg::*;
(
  input  wire logic        clk_sys,      // System clock, 200 MHz.
  input  wire logic        nrst,         // Asynchronous reset, active low.
  input  wire logic [7:0]  addr,         // Register byte address.
  input  wire logic [31:0] wdata,        // Register write data.
  input  wire logic        wr,           // Write strobe.
  input  wire logic        rd,           // Read strobe.
  output logic      [31:0] rdata,        // Read data, valid the cycle after rd.
  input  wire logic        ref_clk_pin,  // Loop reference clock.
  input  wire logic        pll_ena_pin,  // Common loop enable.
  input  wire logic        pll_arst_pin, // Loop reset, active high.
  input  wire logic        pfd_ena_pin,  // Phase detector enable.
  input  wire logic [3:0]  clk_ena_pin,  // Per-port gate enables.
  input  wire logic [15:0] clk_pin,      // Dedicated clock pins.
  output logic      [3:0]  pll_clk,      // Ports: 0,1 global, 2,3 regional.
  output logic             pll_locked,   // Loop in lock.
  output logic             clk_lost,     // Reference clock missing.
  output logic      [15:0] rclk,         // Regional clock networks.
  output logic      [7:0]  io_clk        // I/O region clocks.
);

  pcn_main_t  q;
  pcn_main_t  n;
  logic       pen;
  logic       arst;
  logic       pfd;
  logic       run;
  logic [3:0] ena;
  logic       ref_rise;
  logic [4:0] sel;
  logic [19:0] src;
  logic [21:0] res;

  // ---------------------------------------------
  // Effective controls
  // ---------------------------------------------
  // Pins and register bits are combined for reset, detector and gates, so either user logic
  // or pins may steer them; the common enable comes from its pin alone.
  assign pen  = q.f[`PCN_IN_PEN];
  assign arst = q.f[`PCN_IN_ARST] | q.ctrl[`PCN_CTRL_ARST];
  assign pfd  = q.f[`PCN_IN_PFD] & q.ctrl[`PCN_CTRL_PFD];
  assign ena  = q.f[`PCN_IN_ENA +: 4] & q.ctrl[`PCN_CTRL_ENA +: 4];
  assign run  = (q.st != PCN_OFF);

  // ---------------------------------------------
  // Output ports
  // ---------------------------------------------
  // Each port owns its counter and gate; the loop state machine below
  // never looks at the gates.
  for (genvar k = 0; k < 4; k++) begin : g_port
    pcn_gate u_gate (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .run     (run),
      .div     (q.div[4*k +: 4]),
      .ena     (ena[k]),
      .gclk    (pll_clk[k])
    );
  end

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    n        = q;
    sel      = 5'h00;
    src      = 20'h00000;
    res      = 22'h000000;
    ref_rise = 1'b0;

    // Pin synchroniser: a filtered bit follows once stages two and three agree.
    n.s1 = {ref_clk_pin, pll_ena_pin, pll_arst_pin, pfd_ena_pin, clk_ena_pin, clk_pin};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f  = (q.s2 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));
    ref_rise = n.f[`PCN_IN_REF] & ~q.f[`PCN_IN_REF];

    // Loss of reference: no rising edge within the loss window.
    if (ref_rise) begin
      n.loss_cnt = 8'h00;
      n.clkloss  = 1'b0;
    end else if (q.loss_cnt == 8'(`PCN_LOSS_CYC)) begin
      n.clkloss = 1'b1;
    end else begin
      n.loss_cnt = q.loss_cnt + 8'h01;
    end

    // Loop state machine. The feedback side only watches the reference
    // and the oscillator model, so gating ports cannot unlock it.
    if (!pen || arst) begin
      n.st        = PCN_OFF;
      n.locked    = 1'b0;
      n.lock_cnt  = 4'h0;
      n.drift_cnt = 11'h000;
      n.vco       = `PCN_NOM_MHZ;
    end else begin
      case (q.st)
        PCN_OFF: begin
          n.st = PCN_ACQ;
        end
        PCN_ACQ: begin
          if (!pfd) begin
            n.st = PCN_HOLD;
          end else if (ref_rise) begin
            // Frequency walks from where it stands, nominal after a reset.
            if (q.vco < q.tgt) begin
              n.vco = q.vco + 10'h001;
            end else if (q.vco > q.tgt) begin
              n.vco = q.vco - 10'h001;
            end
            if (q.vco != q.tgt) begin
              n.lock_cnt = 4'h0;
            end else if (q.lock_cnt == `PCN_LOCK_EDGES - 4'h1) begin
              n.st     = PCN_LOCK;
              n.locked = 1'b1;
            end else begin
              n.lock_cnt = q.lock_cnt + 4'h1;
            end
          end
        end
        PCN_LOCK: begin
          if (!pfd) begin
            n.st     = PCN_HOLD;
            n.locked = 1'b0;
          end else if (q.clkloss || q.vco != q.tgt) begin
            n.st       = PCN_ACQ;
            n.locked   = 1'b0;
            n.lock_cnt = 4'h0;
          end
        end
        PCN_HOLD: begin
          // Outputs keep running on the held frequency, drifting slowly down.
          n.locked = 1'b0;
          if (pfd) begin
            n.st        = PCN_ACQ;
            n.lock_cnt  = 4'h0;
            n.drift_cnt = 11'h000;
          end else if (q.drift_cnt == 11'(`PCN_DRIFT_CYC - 1)) begin
            n.drift_cnt = 11'h000;
            if (q.vco != 10'h000) begin
              n.vco = q.vco - 10'h001;
            end
          end else begin
            n.drift_cnt = q.drift_cnt + 11'h001;
          end
        end
        default: begin
          n.st = PCN_OFF;
        end
      endcase
    end

    // Register writes.
    if (wr) begin
      if (addr == `PCN_ADR_CTRL) begin
        n.ctrl = wdata[5:0];
      end else if (addr == `PCN_ADR_TGT) begin
        n.tgt = wdata[9:0];
      end else if (addr == `PCN_ADR_DIV) begin
        n.div = wdata[15:0];
      end else if (addr[7:4] == `PCN_ADR_RSEL && addr[1:0] == 2'b00) begin
        n.rsel[20*addr[3:2] +: 20] = wdata[19:0];
      end else if (addr[7:3] == `PCN_ADR_IOSEL && addr[1:0] == 2'b00) begin
        n.iosel[20*addr[2] +: 20] = wdata[19:0];
      end
    end

    // Register reads; data stand for one cycle, unmapped reads give zero.
    n.rdata = 32'h00000000;
    if (rd) begin
      if (addr == `PCN_ADR_CTRL) begin
        n.rdata = {26'h0000000, q.ctrl};
      end else if (addr == `PCN_ADR_TGT) begin
        n.rdata = {22'h000000, q.tgt};
      end else if (addr == `PCN_ADR_DIV) begin
        n.rdata = {16'h0000, q.div};
      end else if (addr == `PCN_ADR_STAT) begin
        n.rdata[9:0]            = q.vco;
        n.rdata[`PCN_STAT_LOCK] = q.locked;
        n.rdata[`PCN_STAT_LOSS] = q.clkloss;
        n.rdata[`PCN_STAT_ST +: 2] = q.st;
      end else if (addr[7:4] == `PCN_ADR_RSEL && addr[1:0] == 2'b00) begin
        n.rdata = {12'h000, q.rsel[20*addr[3:2] +: 20]};
      end else if (addr[7:3] == `PCN_ADR_IOSEL && addr[1:0] == 2'b00) begin
        n.rdata = {12'h000, q.iosel[20*addr[2] +: 20]};
      end
    end

    // Regional networks take only dedicated pins or loop ports; a select
    // beyond that range parks the network low.
    src = {pll_clk, q.f[15:0]};
    for (int i = 0; i < 16; i++) begin
      sel = q.rsel[5*i +: 5];
      n.rclk[i] = (sel < `PCN_N_PINSRC) ? src[sel] : 1'b0;
    end

    // I/O region clocks pick eight of the 22 resources.
    res = {q.f[1:0], pll_clk, q.rclk};
    for (int j = 0; j < 8; j++) begin
      sel = q.iosel[5*j +: 5];
      n.ioclk[j] = (sel < `PCN_N_IORES) ? res[sel] : 1'b0;
    end
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q      <= '0;
      q.st   <= PCN_OFF;
      q.ctrl <= `PCN_CTRL_RST;
      q.tgt  <= `PCN_TGT_RST;
      q.div  <= `PCN_DIV_RST;
      q.vco  <= `PCN_NOM_MHZ;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign rdata      = q.rdata;
  assign pll_locked = q.locked;
  assign clk_lost   = q.clkloss;
  assign rclk       = q.rclk;
  assign io_clk     = q.ioclk;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_ena_off: assert property (
    !pen |=> q.st == PCN_OFF && !q.locked)
    else $error("Loop still active after enable went low.");

  a_off_out: assert property (
    q.st == PCN_OFF [*2] |-> pll_clk == 4'h0)
    else $error("Output clocks not cleared while loop is off.");

  a_rst_nom: assert property (
    arst |=> q.vco == `PCN_NOM_MHZ && q.st == PCN_OFF)
    else $error("Oscillator not at nominal during reset.");

  a_relock: assert property (
    $rose(q.locked) |-> $past(q.st) == PCN_ACQ && q.st == PCN_LOCK && q.vco == q.tgt)
    else $error("Lock raised outside acquisition or off target.");

  a_hold_keep: assert property (
    q.st == PCN_HOLD && $past(q.st) == PCN_HOLD |-> q.vco <= $past(q.vco) && run)
    else $error("Held frequency rose or outputs stopped.");

  a_rclk_park: assert property (
    q.rsel[4:0] >= `PCN_N_PINSRC |=> !q.rclk[0])
    else $error("Regional network driven by an illegal source.");

  a_stat_read: assert property (
    rd && addr == `PCN_ADR_STAT |=> q.rdata[9:0] == $past(q.vco))
    else $error("Status read does not show oscillator frequency.");

  a_io_sel: assert property (
    q.iosel[4:0] == 5'h10 ##1 q.iosel[4:0] == 5'h10 |-> q.ioclk[0] == $past(pll_clk[0]))
    else $error("I/O clock does not follow its selected resource.");

  c_lock: cover property ($rose(q.locked));
  c_hold: cover property (q.st == PCN_LOCK ##1 q.st == PCN_HOLD);
  c_relock: cover property (q.st == PCN_OFF ##1 q.st == PCN_ACQ);

endmodule
`default_nettype wire

// File: design/pcn_defs.svh
// Offsets, field positions, reset values and timing counts of the PLL clock control block.
`ifndef PCN_DEFS_SVH
`define PCN_DEFS_SVH

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define PCN_CLK_PERIOD_NS 5
`define PCN_LOSS_TIME_NS  1000
`define PCN_LOSS_CYC      (`PCN_LOSS_TIME_NS / `PCN_CLK_PERIOD_NS)
`define PCN_DRIFT_TIME_NS 10000
`define PCN_DRIFT_CYC     (`PCN_DRIFT_TIME_NS / `PCN_CLK_PERIOD_NS)
`define PCN_LOCK_EDGES    4'h8

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define PCN_NOM_MHZ  10'h2bc
`define PCN_TGT_RST  10'h258
`define PCN_DIV_RST  16'h1111
`define PCN_CTRL_RST 6'h2f

// ---------------------------------------------
// Register offsets and fields
// ---------------------------------------------
`define PCN_ADR_CTRL  8'h00
`define PCN_ADR_TGT   8'h04
`define PCN_ADR_DIV   8'h08
`define PCN_ADR_STAT  8'h0c
`define PCN_ADR_RSEL  4'h1
`define PCN_ADR_IOSEL 5'h04
`define PCN_CTRL_ENA  0
`define PCN_CTRL_ARST 4
`define PCN_CTRL_PFD  5
`define PCN_STAT_LOCK 10
`define PCN_STAT_LOSS 11
`define PCN_STAT_ST   12

// ---------------------------------------------
// Synchronised input vector positions and clock source counts
// ---------------------------------------------
`define PCN_IN_ENA  16
`define PCN_IN_PFD  20
`define PCN_IN_ARST 21
`define PCN_IN_PEN  22
`define PCN_IN_REF  23
`define PCN_N_PINSRC 5'h14
`define PCN_N_IORES  5'h16

`endif

// File: design/pcn_pkg.sv
// Types shared by the PLL clock control block.
package pcn_pkg;

  // Loop states, Gray coded along off, acquire, lock, hold.
  typedef enum logic [1:0] {
    PCN_OFF  = 2'b00,
    PCN_ACQ  = 2'b01,
    PCN_LOCK = 2'b11,
    PCN_HOLD = 2'b10
  } pcn_state_t;

  // State of one post-scale counter with its output gate.
  typedef struct packed {
    logic [3:0] cnt;
    logic       ph;
    logic       en_q;
    logic       out;
  } pcn_gate_t;

  // State of the control block.
  typedef struct packed {
    logic [23:0] s1;
    logic [23:0] s2;
    logic [23:0] s3;
    logic [23:0] f;
    pcn_state_t  st;
    logic [5:0]  ctrl;
    logic [9:0]  tgt;
    logic [15:0] div;
    logic [79:0] rsel;
    logic [39:0] iosel;
    logic [9:0]  vco;
    logic [3:0]  lock_cnt;
    logic        locked;
    logic [7:0]  loss_cnt;
    logic        clkloss;
    logic [10:0] drift_cnt;
    logic [31:0] rdata;
    logic [15:0] rclk;
    logic [7:0]  ioclk;
  } pcn_main_t;

endpackage

// File: design/pcn_gate.sv
// One post-scale output counter with its glitch-free clock gate.
`timescale 1ns/1ps
`default_nettype none

module pcn_gate
  import pcn_pkg::*;
(
  input  wire logic       clk_sys, // System clock.
  input  wire logic       nrst,    // Asynchronous reset, active low.
  input  wire logic       run,     // Loop running; low clears the counter.
  input  wire logic [3:0] div,     // Half period minus one, in cycles.
  input  wire logic       ena,     // Output gate enable.
  output logic            gclk     // Gated counter output.
);

  pcn_gate_t q;
  pcn_gate_t n;

  // ---------------------------------------------
  // Counter and gate
  // ---------------------------------------------
  // The enable is only taken while the counter output falls, so the
  // gated clock never starts or stops in the middle of a high phase.
  always_comb begin
    n = q;
    if (!run) begin
      n = '0;
    end else begin
      if (q.cnt == div) begin
        n.cnt = 4'h0;
        n.ph  = ~q.ph;
        if (q.ph) begin
          n.en_q = ena;
        end
      end else begin
        n.cnt = q.cnt + 4'h1;
      end
      n.out = n.ph & n.en_q;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign gclk = q.out;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  a_gate_edge: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(run) && $changed(q.en_q) |-> $fell(q.ph))
    else $error("Gate enable changed away from a falling counter edge.");

  a_no_runt: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(run) && $fell(q.out) |-> $fell(q.ph))
    else $error("Gated clock fell before the end of its high phase.");

  c_gate_on: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(q.en_q));

endmodule
`default_nettype wire

// File: testbench/pcn_fabric.sv
// Fabric-side model that makes the reference clock and drives the loop controls.
`timescale 1ns/1ps
`default_nettype none

module pcn_fabric #(
  parameter int HALF = 4 // Reference half period in system cycles.
) (
  input  wire logic clk_sys,        // System clock.
  input  wire logic run,            // Reference clock running.
  input  wire logic ena_req,        // Requested common enable.
  input  wire logic pfd_req,        // Requested detector enable.
  input  wire logic use_loss,       // Let the loss status close the detector.
  input  wire logic clk_lost,       // Loss status from the block.
  output logic      ref_clk = 1'b0, // Reference clock pin.
  output logic      ena_pin,        // Common enable pin.
  output logic      pfd_pin         // Detector enable pin.
);
  int cnt = 0;

  // The reference comes from a pin-like source, and it parks low when stopped so no stale edge survives.
  always @(posedge clk_sys) begin
    if (!run) begin
      ref_clk <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      ref_clk <= ~ref_clk;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Every loop under test is wired to the common enable.
  assign ena_pin = ena_req;
  // The loss status may close the detector so that the outputs keep running.
  assign pfd_pin = pfd_req & ~(use_loss & clk_lost);
endmodule

`default_nettype wire

// File: testbench/pcn_top_tb.sv
// Self-checking bench for the loop control and clock routing block.
`timescale 1ns/1ps
`default_nettype none

module pcn_top_tb;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        arst = 1'b0;
  logic [3:0]  clk_ena = 4'hf;
  logic [15:0] clk_pin = 16'h0;
  logic        ena_req = 1'b0;
  logic        pfd_req = 1'b1;
  logic        use_loss = 1'b0;
  logic        ref_run = 1'b1;
  logic [31:0] rdata;
  logic        ref_clk_pin, pll_ena_pin, pfd_ena_pin, pll_locked, clk_lost;
  logic [3:0]  pll_clk;
  logic [15:0] rclk;
  logic [7:0]  io_clk;
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          compares = 0;

  always #2.5 clk_sys = ~clk_sys;

  pcn_fabric i_fab (.clk_sys(clk_sys), .run(ref_run), .ena_req(ena_req), .pfd_req(pfd_req), .use_loss(use_loss),
    .clk_lost(clk_lost), .ref_clk(ref_clk_pin), .ena_pin(pll_ena_pin), .pfd_pin(pfd_ena_pin));

  pcn_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ref_clk_pin(ref_clk_pin), .pll_ena_pin(pll_ena_pin), .pll_arst_pin(arst), .pfd_ena_pin(pfd_ena_pin),
    .clk_ena_pin(clk_ena), .clk_pin(clk_pin), .pll_clk(pll_clk), .pll_locked(pll_locked), .clk_lost(clk_lost),
    .rclk(rclk), .io_clk(io_clk));

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // The expected word is noted first; the monitor takes it when the answer stands.
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there and only there.
  always @(posedge clk_sys) begin
    rd_q <= rd;
    if (rd_q) check("rdata", rdata, exp_q.pop_front());
  end

  task automatic wait_lock();
    int i;
    i = 0;
    while (pll_locked !== 1'b1 && i < 3000) begin
      @(posedge clk_sys);
      i++;
    end
    check("pll_locked", pll_locked, 1'b1);
  endtask

  // Counts rising edges of every port over 48 cycles; with a divider of 0x3210 port p has period 2p+2.
  task automatic port_counts(input logic [3:0] on);
    int c;
    logic prev;
    for (int p = 0; p < 4; p++) begin
      c = 0;
      prev = pll_clk[p];
      repeat (48) begin
        @(posedge clk_sys);
        if (prev === 1'b0 && pll_clk[p] === 1'b1) c++;
        prev = pll_clk[p];
      end
      check("port rises", c, on[p] ? 48 / (2 * p + 2) : 0);
    end
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    integer seed;
    logic [4:0] sel [24];
    logic [31:0] w;
    logic [15:0] pins, er;
    logic [21:0] res;
    seed = 32'h3d21e2d4;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    // Reset values, reserved bits, a read-only and an unmapped place.
    bus_rd(8'h00, 32'h2f);
    bus_rd(8'h08, 32'h1111);
    bus_rd(8'h0c, 32'h2bc);
    bus_wr(8'h0c, 32'h0);
    bus_rd(8'h0c, 32'h2bc);
    bus_wr(8'h30, 32'hffffffff);
    bus_rd(8'h30, 32'h0);
    bus_wr(8'h04, 32'hffffffff);
    bus_rd(8'h04, 32'h3ff);
    // Random routing while the loop is off, so every loop port reads as low.
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 24; i++) sel[i] = 5'($unsigned($random(seed)) % (i < 16 ? 21 : 23));
      pins = 16'($random(seed));
      @(posedge clk_sys);
      clk_pin <= pins;
      for (int k = 0; k < 6; k++) begin
        w = {12'h0, sel[4 * k + 3], sel[4 * k + 2], sel[4 * k + 1], sel[4 * k]};
        bus_wr(8'h10 + 8'(4 * k), w);
        bus_rd(8'h10 + 8'(4 * k), w);
      end
      cyc(12);
      for (int i = 0; i < 16; i++) er[i] = sel[i] < 16 ? pins[sel[i]] : 1'b0;
      res = {pins[1:0], 4'h0, er};
      check("rclk", rclk, er);
      for (int j = 0; j < 8; j++) check("io_clk", io_clk[j], sel[16 + j] < 22 ? res[sel[16 + j]] : 1'b0);
    end
    // First lock and all four ports running.
    bus_wr(8'h04, 32'h2b4);
    bus_wr(8'h08, 32'h3210);
    ena_req <= 1'b1;
    wait_lock();
    bus_rd(8'h0c, 32'h36b4);
    port_counts(4'hf);
    // Gates closed by pin on port 0 and by register on port 1; the loop must stay locked.
    clk_ena <= 4'he;
    bus_wr(8'h00, 32'h2d);
    cyc(20);
    port_counts(4'hc);
    check("pll_clk low", pll_clk[1:0], 2'b00);
    check("pll_locked", pll_locked, 1'b1);
    clk_ena <= 4'hf;
    bus_wr(8'h00, 32'h2f);
    cyc(20);
    port_counts(4'hf);
    // Detector off: frequency is held, drifts down slowly, and the outputs keep running.
    pfd_req <= 1'b0;
    cyc(10);
    bus_rd(8'h0c, 32'h22b4);
    port_counts(4'hf);
    cyc(1900);
    bus_rd(8'h0c, 32'h22b3);
    pfd_req <= 1'b1;
    wait_lock();
    // Reset pin, soft reset and enable low each clear the loop and restart it from nominal.
    for (int k = 0; k < 3; k++) begin
      if (k == 0) begin
        arst <= 1'b1;
      end else if (k == 1) begin
        bus_wr(8'h00, 32'h3f);
      end else begin
        ena_req <= 1'b0;
      end
      cyc(10);
      check("pll_locked", pll_locked, 1'b0);
      check("pll_clk", pll_clk, 4'h0);
      bus_rd(8'h0c, 32'h2bc);
      arst <= 1'b0;
      ena_req <= 1'b1;
      bus_wr(8'h00, 32'h2f);
      wait_lock();
      port_counts(4'hf);
    end
    // Reference lost with the loss status closing the detector, then a reset pulse to relock.
    use_loss <= 1'b1;
    ref_run <= 1'b0;
    cyc(260);
    check("clk_lost", clk_lost, 1'b1);
    port_counts(4'hf);
    ref_run <= 1'b1;
    cyc(40);
    check("clk_lost", clk_lost, 1'b0);
    use_loss <= 1'b0;
    clk_ena <= 4'h0;
    arst <= 1'b1;
    cyc(10);
    arst <= 1'b0;
    wait_lock();
    check("pll_clk gated", pll_clk, 4'h0);
    clk_ena <= 4'hf;
    cyc(20);
    port_counts(4'hf);
    bus_rd(8'h0c, 32'h36b4);
    cyc(5);
    results();
  end

  // The whole run needs about 5000 cycles; a hang is cut off well beyond that.
  initial begin
    #(5 * 30000);
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
